// ==== verilog/stw_regs.svh ====
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 32-bit byte addresses on the plain register port
// Notes:   definitions only, shared by every design file but the package
`ifndef STW_REGS_SVH
`define STW_REGS_SVH

// register byte addresses
`define STW_ADDR_ARM        32'h4000_6004
`define STW_ADDR_KICK       32'h4000_6008
`define STW_ADDR_CFG        32'h4000_600c
`define STW_ADDR_CNT_UPPER  32'h4000_6010
`define STW_ADDR_CNT_LOWER  32'h4000_6014
`define STW_ADDR_MA_UPPER   32'h4000_6018
`define STW_ADDR_MA_LOWER   32'h4000_601c
`define STW_ADDR_MB_UPPER   32'h4000_6020
`define STW_ADDR_MB_LOWER   32'h4000_6024

// slow_timer_config field positions
`define STW_CFG_DIR_BIT     12
`define STW_CFG_RUN_BIT     11
`define STW_CFG_FRZ_BIT     10
`define STW_CFG_PRE_HI      7
`define STW_CFG_PRE_LO      4
`define STW_CFG_SRC_BIT     0

// reset values
`define STW_CFG_RESET       32'h0000_0400
`define STW_MATCH_RESET     16'hffff
`define STW_KEY_RESET       16'h0000

// arming keys
`define STW_KEY_OFF         16'hdead
`define STW_KEY_ON          16'heabe

// watchdog timing on the 1 kHz reference
`define STW_KHZ_RATE_HZ     1000
`define STW_WDOG_TIMEOUT_MS 2048
`define STW_WDOG_WARN_MS    1792
`define STW_WDOG_TIMEOUT_TICKS ((`STW_WDOG_TIMEOUT_MS * `STW_KHZ_RATE_HZ) / 1000)
`define STW_WDOG_WARN_TICKS    ((`STW_WDOG_WARN_MS * `STW_KHZ_RATE_HZ) / 1000)

`endif

// ==== verilog/stw_pkg.sv ====
// Purpose: shared types of the slow timer and watchdog block
// Assumes: offsets and counts live in stw_regs.svh
// Notes:   types only
package stw_pkg;

  // decoded slow_timer_config fields
  typedef struct packed {
    logic       dir;     // count_direction: 1 counts down
    logic       run;     // slow_counter_run
    logic       freeze;  // halt_freeze
    logic [3:0] pre;     // prescale_exponent
    logic       src;     // tick_source_select: 1 crystal
  } stw_cfg_t;

  // one-cycle sleep timer events
  typedef struct packed {
    logic cmp_b;  // match b reached
    logic cmp_a;  // match a reached
    logic wrap;   // rollover
  } stw_evt_t;

  // watchdog run state
  typedef enum logic [0:0] {
    STW_WD_OFF = 1'b0,
    STW_WD_ON  = 1'b1
  } stw_wd_state_t;

endpackage

// ==== verilog/stw_prescale.sv ====
// Purpose: power-of-two prescaler for the selected slow tick
// Assumes: tick_i is a one-cycle enable pulse in the clk_i domain
// Notes:   pulse_o is combinational, one cycle, aligned with tick_i
`timescale 1ns/10ps
`include "stw_regs.svh"
module stw_prescale
  import stw_pkg::*;
#(
  parameter int PRE_W = 15,  // prescale counter width
  parameter int EXP_W = 4    // exponent width
) (
  input  wire logic             clk_i,    // system clock
  input  wire logic             rst_n_i,  // sync reset, active low
  input  wire logic             tick_i,   // selected tick pulse
  input  wire logic [EXP_W-1:0] exp_i,    // divide by 2**exp_i
  input  wire logic             clear_i,  // hold the divider at zero
  output logic                  pulse_o   // divided tick pulse
);

  // elaboration check: counter must cover the largest exponent
  if (PRE_W < (1 << EXP_W) - 1) begin : g_chk
    $error("stw_prescale: PRE_W too small for EXP_W");
  end

  logic [PRE_W-1:0] cnt_reg;   // free divider count
  logic [PRE_W-1:0] cnt_next;  // next divider count
  logic [PRE_W-1:0] mask;      // low exp_i bits set

  ///////////////////////////////////////////////////////////////////////////
  // divider next state and output pulse
  always_comb begin
    mask = PRE_W'((32'h1 << exp_i) - 32'h1);
    pulse_o = tick_i & ((cnt_reg & mask) == mask);
    if (clear_i) begin
      cnt_next = '0;  // stopped: restart phase
    end else if (tick_i) begin
      cnt_next = cnt_reg + PRE_W'(1);
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // divider register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

// ==== verilog/stw_watchdog.sv ====
// Purpose: key-protected watchdog with early warning and timeout
// Assumes: khz_tick_i is the 1 kHz reference as a one-cycle pulse
// Notes:   on/off requests are single-cycle pulses from the bits register
`timescale 1ns/10ps
`include "stw_regs.svh"
module stw_watchdog
  import stw_pkg::*;
#(
  parameter int WD_W = 12  // tick counter width
) (
  input  wire logic        clk_i,       // system clock
  input  wire logic        rst_n_i,     // sync reset, active low
  input  wire logic        khz_tick_i,  // 1 kHz reference tick
  input  wire logic        key_wr_i,    // arming key write strobe
  input  wire logic [15:0] key_i,       // written key value
  input  wire logic        kick_i,      // restart strobe
  input  wire logic        on_req_i,    // turn-on bit pulse
  input  wire logic        off_req_i,   // turn-off bit pulse
  output logic             on_o,        // watchdog running
  output logic             warn_o,      // early warning pulse
  output logic             expire_o     // timeout pulse
);

  // elaboration check: counter must hold the full timeout
  if ((1 << WD_W) <= `STW_WDOG_TIMEOUT_TICKS) begin : g_chk
    $error("stw_watchdog: WD_W too small for timeout");
  end

  localparam logic [WD_W-1:0] TIMEOUT = WD_W'(`STW_WDOG_TIMEOUT_TICKS);
  localparam logic [WD_W-1:0] WARN    = WD_W'(`STW_WDOG_WARN_TICKS);

  stw_wd_state_t   st_reg,   st_next;    // run state
  logic [15:0]     key_reg,  key_next;   // arming key
  logic [WD_W-1:0] cnt_reg,  cnt_next;   // ticks since kick
  logic            warn_reg, warn_next;  // warning pulse
  logic            exp_reg,  exp_next;   // expiry pulse

  ///////////////////////////////////////////////////////////////////////////
  // key, state and tick count next values
  always_comb begin
    st_next   = st_reg;
    key_next  = key_reg;
    cnt_next  = cnt_reg;
    warn_next = 1'b0;
    exp_next  = 1'b0;
    if (key_wr_i) begin
      key_next = key_i;
    end
    case (st_reg)
      STW_WD_OFF: begin
        cnt_next = '0;
        if (on_req_i && key_reg == `STW_KEY_ON) begin
          st_next  = STW_WD_ON;
          key_next = `STW_KEY_RESET;  // one arming per change
        end
      end
      STW_WD_ON: begin
        if (off_req_i && key_reg == `STW_KEY_OFF) begin
          st_next  = STW_WD_OFF;
          key_next = `STW_KEY_RESET;
          cnt_next = '0;
        end else if (kick_i) begin
          cnt_next = '0;
        end else if (khz_tick_i) begin
          cnt_next  = cnt_reg + WD_W'(1);
          warn_next = (cnt_next == WARN);
          if (cnt_next == TIMEOUT) begin
            exp_next = 1'b1;
            cnt_next = '0;
          end
        end
      end
      default: st_next = STW_WD_OFF;
    endcase
  end

  // watchdog registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg   <= STW_WD_OFF;
      key_reg  <= `STW_KEY_RESET;
      cnt_reg  <= '0;
      warn_reg <= 1'b0;
      exp_reg  <= 1'b0;
    end else begin
      st_reg   <= st_next;
      key_reg  <= key_next;
      cnt_reg  <= cnt_next;
      warn_reg <= warn_next;
      exp_reg  <= exp_next;
    end
  end

  assign on_o     = (st_reg == STW_WD_ON);
  assign warn_o   = warn_reg;
  assign expire_o = exp_reg;

endmodule

// ==== verilog/stw_top.sv ====
// Purpose: always-on slow timer and watchdog register block
// Assumes: ticks and halt are synchronous to clk_i, one-cycle tick pulses
// Notes:   read data appear one cycle after the read strobe, else zero
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`include "stw_regs.svh"
module stw_top
  import stw_pkg::*;
#(
  parameter int CNT_W = 32,  // sleep counter width
  parameter int PRE_W = 15   // prescale counter width
) (
  input  wire logic        clk_i,        // 40 MHz system clock
  input  wire logic        rst_n_i,      // sync reset, active low
  input  wire logic [31:0] addr_i,       // register byte address
  input  wire logic [31:0] wdata_i,      // write data
  input  wire logic        wr_i,         // write strobe
  input  wire logic        rd_i,         // read strobe
  output logic      [31:0] rdata_o,      // read data, next cycle
  input  wire logic        calibrated_khz_tick_i,  // 1 kHz tick pulse
  input  wire logic        crystal_watch_tick_i,   // 32 kHz tick pulse
  input  wire logic        halted_i,     // debugger halts the core
  input  wire logic        watchdog_turn_on_bit_i,  // turn-on bit pulse
  input  wire logic        watchdog_turn_off_bit_i, // turn-off bit pulse
  output stw_evt_t         evt_o,        // timer event pulses
  output logic             wdog_on_o,    // watchdog running
  output logic             wdog_warn_o,  // early warning pulse
  output logic             wdog_expire_o // timeout pulse
);

  // elaboration check: register layout is fixed at 32 bits
  if (CNT_W != 32) begin : g_chk
    $error("stw_top: CNT_W must be 32");
  end

  ///////////////////////////////////////////////////////////////////////////
  // address decode helper
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  // write strobes per register and the count upper read strobe
  logic wr_arm;    // arming key write
  logic wr_kick;   // kick write
  logic wr_cfg;    // config write
  logic wr_mau;    // match a upper write
  logic wr_mal;    // match a lower write
  logic wr_mbu;    // match b upper write
  logic wr_mbl;    // match b lower write
  logic rd_cntu;   // count upper read

  always_comb begin
    wr_arm  = wr_i & hit(addr_i, `STW_ADDR_ARM);
    wr_kick = wr_i & hit(addr_i, `STW_ADDR_KICK);
    wr_cfg  = wr_i & hit(addr_i, `STW_ADDR_CFG);
    wr_mau  = wr_i & hit(addr_i, `STW_ADDR_MA_UPPER);
    wr_mal  = wr_i & hit(addr_i, `STW_ADDR_MA_LOWER);
    wr_mbu  = wr_i & hit(addr_i, `STW_ADDR_MB_UPPER);
    wr_mbl  = wr_i & hit(addr_i, `STW_ADDR_MB_LOWER);
    rd_cntu = rd_i & hit(addr_i, `STW_ADDR_CNT_UPPER);
  end

  ///////////////////////////////////////////////////////////////////////////
  // configuration register
  stw_cfg_t cfg_reg;   // live configuration
  stw_cfg_t cfg_next;  // next configuration

  always_comb begin
    cfg_next = cfg_reg;
    if (wr_cfg) begin
      cfg_next.run    = wdata_i[`STW_CFG_RUN_BIT];
      cfg_next.freeze = wdata_i[`STW_CFG_FRZ_BIT];
      if (!cfg_reg.run) begin
        cfg_next.dir = wdata_i[`STW_CFG_DIR_BIT];
        cfg_next.pre = wdata_i[`STW_CFG_PRE_HI:`STW_CFG_PRE_LO];
        cfg_next.src = wdata_i[`STW_CFG_SRC_BIT];
      end
    end
  end

  // configuration flops, reset from the documented reset word
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_reg.dir    <= 1'(`STW_CFG_RESET >> `STW_CFG_DIR_BIT);
      cfg_reg.run    <= 1'(`STW_CFG_RESET >> `STW_CFG_RUN_BIT);
      cfg_reg.freeze <= 1'(`STW_CFG_RESET >> `STW_CFG_FRZ_BIT);
      cfg_reg.pre    <= 4'(`STW_CFG_RESET >> `STW_CFG_PRE_LO);
      cfg_reg.src    <= 1'(`STW_CFG_RESET >> `STW_CFG_SRC_BIT);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // tick selection and run-bit resampling on the selected tick
  logic src_tick;    // selected raw tick
  logic run_s1_reg;  // first tick sample of run
  logic run_s1_next; // next first sample
  logic run_s2_reg;  // run as seen by the counter
  logic run_s2_next; // next counter run
  logic pre_pulse;   // prescaled tick

  always_comb begin
    src_tick = cfg_reg.src ? crystal_watch_tick_i
                           : calibrated_khz_tick_i;
    run_s1_next = run_s1_reg;
    run_s2_next = run_s2_reg;
    if (src_tick) begin
      run_s1_next = cfg_reg.run;
      run_s2_next = run_s1_reg;
    end
  end

  // run resampling flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
    end else begin
      run_s1_reg <= run_s1_next;
      run_s2_reg <= run_s2_next;
    end
  end

  // prescaler, parked at zero while the counter is stopped
  stw_prescale #(
    .PRE_W (PRE_W),
    .EXP_W (4)
  ) u_pre (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (src_tick),
    .exp_i   (cfg_reg.pre),
    .clear_i (!run_s2_reg),
    .pulse_o (pre_pulse)
  );

  ///////////////////////////////////////////////////////////////////////////
  // sleep counter, events and count snapshot
  logic [CNT_W-1:0] cnt_reg;   // sleep count
  logic [CNT_W-1:0] cnt_next;  // next sleep count
  logic [15:0]      snap_reg;  // lower half caught by upper read
  logic [15:0]      snap_next; // next snapshot
  logic             step;      // counter advances this cycle
  stw_evt_t         evt_reg;   // event pulses
  stw_evt_t         evt_next;  // next event pulses
  logic [CNT_W-1:0] ma_reg;    // match a
  logic [CNT_W-1:0] ma_next;   // next match a
  logic [15:0]      hla_reg;   // match a lower hold
  logic [15:0]      hla_next;  // next hold a
  logic [CNT_W-1:0] mb_reg;    // match b
  logic [CNT_W-1:0] mb_next;   // next match b
  logic [15:0]      hlb_reg;   // match b lower hold
  logic [15:0]      hlb_next;  // next hold b

  always_comb begin
    step = pre_pulse & run_s2_reg & !(cfg_reg.freeze & halted_i);
    cnt_next = cnt_reg;
    evt_next = '0;
    if (step) begin
      cnt_next = cfg_reg.dir ? cnt_reg - CNT_W'(1)
                             : cnt_reg + CNT_W'(1);
      evt_next.wrap  = cfg_reg.dir ? (cnt_reg == '0)
                                   : (cnt_reg == '1);
      evt_next.cmp_a = (cnt_next == ma_reg);
      evt_next.cmp_b = (cnt_next == mb_reg);
    end
    snap_next = snap_reg;
    if (rd_cntu) begin
      snap_next = cnt_reg[15:0];
    end
  end

  // counter, snapshot and event flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= '0;
      snap_reg <= '0;
      evt_reg  <= '0;
    end else begin
      cnt_reg  <= cnt_next;
      snap_reg <= snap_next;
      evt_reg  <= evt_next;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // match values with lower-half holding latches

  always_comb begin
    ma_next  = ma_reg;
    hla_next = hla_reg;
    mb_next  = mb_reg;
    hlb_next = hlb_reg;
    if (wr_mal) begin
      hla_next = wdata_i[15:0];
    end
    if (wr_mau) begin
      ma_next = {wdata_i[15:0], hla_reg};
    end
    if (wr_mbl) begin
      hlb_next = wdata_i[15:0];
    end
    if (wr_mbu) begin
      mb_next = {wdata_i[15:0], hlb_reg};
    end
  end

  // match flops, all halves reset to ones
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ma_reg  <= {`STW_MATCH_RESET, `STW_MATCH_RESET};
      hla_reg <= `STW_MATCH_RESET;
      mb_reg  <= {`STW_MATCH_RESET, `STW_MATCH_RESET};
      hlb_reg <= `STW_MATCH_RESET;
    end else begin
      ma_reg  <= ma_next;
      hla_reg <= hla_next;
      mb_reg  <= mb_next;
      hlb_reg <= hlb_next;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // read data path: one cycle after the strobe, zero otherwise
  logic [31:0] rdata_reg;   // registered read data
  logic [31:0] rdata_next;  // next read data
  logic [31:0] rd_mux;      // selected register word

  always_comb begin
    rd_mux = 32'h0;  // write-only and unmapped read as zero
    if (hit(addr_i, `STW_ADDR_CFG)) begin
      rd_mux[`STW_CFG_DIR_BIT] = cfg_reg.dir;
      rd_mux[`STW_CFG_RUN_BIT] = cfg_reg.run;
      rd_mux[`STW_CFG_FRZ_BIT] = cfg_reg.freeze;
      rd_mux[`STW_CFG_PRE_HI:`STW_CFG_PRE_LO] = cfg_reg.pre;
      rd_mux[`STW_CFG_SRC_BIT] = cfg_reg.src;
    end else if (hit(addr_i, `STW_ADDR_CNT_UPPER)) begin
      rd_mux[15:0] = cnt_reg[31:16];
    end else if (hit(addr_i, `STW_ADDR_CNT_LOWER)) begin
      rd_mux[15:0] = snap_reg;
    end else if (hit(addr_i, `STW_ADDR_MA_UPPER)) begin
      rd_mux[15:0] = ma_reg[31:16];
    end else if (hit(addr_i, `STW_ADDR_MA_LOWER)) begin
      rd_mux[15:0] = ma_reg[15:0];
    end else if (hit(addr_i, `STW_ADDR_MB_UPPER)) begin
      rd_mux[15:0] = mb_reg[31:16];
    end else if (hit(addr_i, `STW_ADDR_MB_LOWER)) begin
      rd_mux[15:0] = mb_reg[15:0];
    end
    rdata_next = rd_i ? rd_mux : 32'h0;
  end

  // read data flop
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // watchdog on the 1 kHz reference
  stw_watchdog #(
    .WD_W (12)
  ) u_wdog (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .khz_tick_i (calibrated_khz_tick_i),
    .key_wr_i   (wr_arm),
    .key_i      (wdata_i[15:0]),
    .kick_i     (wr_kick),
    .on_req_i   (watchdog_turn_on_bit_i),
    .off_req_i  (watchdog_turn_off_bit_i),
    .on_o       (wdog_on_o),
    .warn_o     (wdog_warn_o),
    .expire_o   (wdog_expire_o)
  );

  // outputs straight from flops
  assign rdata_o = rdata_reg;
  assign evt_o   = evt_reg;

endmodule

// ==== testbench/stw_top_monitor.sv ====
// Purpose: concurrent checks on the slow timer and watchdog ports
// Assumes: one clock, synchronous active-low reset
// Notes:   small mirrors of key, config and watchdog count
`timescale 1ns/10ps
`include "stw_regs.svh"
module stw_top_monitor
  import stw_pkg::*;
#(
  parameter int CNT_W = 32,  // counter width
  parameter int PRE_W = 15   // prescaler width
) (
  input wire logic        clk_i,                   // clock
  input wire logic        rst_n_i,                 // reset
  input wire logic [31:0] addr_i,                  // address
  input wire logic [31:0] wdata_i,                 // write data
  input wire logic        wr_i,                    // write strobe
  input wire logic        rd_i,                    // read strobe
  input wire logic [31:0] rdata_o,                 // read data
  input wire logic        calibrated_khz_tick_i,   // 1 kHz tick
  input wire logic        crystal_watch_tick_i,    // 32 kHz tick
  input wire logic        halted_i,                // halt
  input wire logic        watchdog_turn_on_bit_i,  // on pulse
  input wire logic        watchdog_turn_off_bit_i, // off pulse
  input wire stw_evt_t    evt_o,                   // events
  input wire logic        wdog_on_o,               // running
  input wire logic        wdog_warn_o,             // warning
  input wire logic        wdog_expire_o            // timeout
);
  logic [15:0] key_reg, key_next;  // last arming key
  logic        on_reg;             // previous run state
  logic [11:0] wd_reg, wd_next;    // ticks since restart
  logic [12:0] cfg_reg, cfg_next;  // config mirror
  logic        sel_tick;           // selected tick
  logic        frz_halt;           // counter frozen

  ////////////////////////////////////////////////////////////
  // mirror next values
  always_comb begin
    key_next = key_reg;
    wd_next  = wd_reg + {11'h0, calibrated_khz_tick_i};
    cfg_next = cfg_reg;
    if (wr_i && addr_i == `STW_ADDR_ARM) begin
      key_next = wdata_i[15:0];
    end else if (wdog_on_o != on_reg) begin  // key consumed
      key_next = 16'h0;
    end
    if (!wdog_on_o || (wr_i && addr_i == `STW_ADDR_KICK) ||
        (calibrated_khz_tick_i && wd_reg == 12'h7ff)) begin
      wd_next = 12'h0;
    end
    if (wr_i && addr_i == `STW_ADDR_CFG) begin
      if (cfg_reg[11]) begin  // running: run and freeze only
        cfg_next[11:10] = wdata_i[11:10];
      end else begin
        cfg_next = wdata_i[12:0] & 13'h1cf1;
      end
    end
  end

  // mirror registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      key_reg <= 16'h0;
      on_reg  <= 1'b0;
      wd_reg  <= 12'h0;
      cfg_reg <= 13'h0400;
    end else begin
      key_reg <= key_next;
      on_reg  <= wdog_on_o;
      wd_reg  <= wd_next;
      cfg_reg <= cfg_next;
    end
  end

  assign sel_tick = cfg_reg[0] ? crystal_watch_tick_i : calibrated_khz_tick_i;
  assign frz_halt = halted_i & cfg_reg[10];

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_idle_read_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read");
  a_wo_read_zero: assert property ($past(rd_i) && ($past(addr_i) == `STW_ADDR_ARM ||
    $past(addr_i) == `STW_ADDR_KICK) |-> rdata_o == 32'h0)
    else $error("write-only register read nonzero");
  a_cfg_readback: assert property ($past(rd_i) && $past(addr_i) == `STW_ADDR_CFG
    |-> rdata_o == {19'h0, $past(cfg_reg)})
    else $error("config readback wrong");
  a_on_needs_key: assert property ($rose(wdog_on_o) |->
    $past(watchdog_turn_on_bit_i) && $past(key_reg) == `STW_KEY_ON)
    else $error("watchdog turned on without key");
  a_off_needs_key: assert property ($fell(wdog_on_o) |->
    $past(watchdog_turn_off_bit_i) && $past(key_reg) == `STW_KEY_OFF)
    else $error("watchdog turned off without key");
  a_warn_at_count: assert property (wdog_warn_o |-> wd_reg == 12'h700)
    else $error("warning at wrong tick count");
  a_expire_at_count: assert property (wdog_expire_o |->
    $past(wd_reg) == 12'h7ff && $past(calibrated_khz_tick_i))
    else $error("timeout at wrong tick count");
  a_evt_after_tick: assert property (evt_o != 3'h0 |-> $past(sel_tick))
    else $error("event without selected tick");
  a_frozen_no_evt: assert property ($past(frz_halt) |-> evt_o == 3'h0)
    else $error("event while frozen");

  c_warn: cover property (wdog_warn_o);
  c_wrap: cover property (evt_o.wrap);
  c_match_a: cover property (evt_o.cmp_a);
endmodule

bind stw_top stw_top_monitor #(.CNT_W(CNT_W), .PRE_W(PRE_W)) u_mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .calibrated_khz_tick_i(calibrated_khz_tick_i),
  .crystal_watch_tick_i(crystal_watch_tick_i), .halted_i(halted_i),
  .watchdog_turn_on_bit_i(watchdog_turn_on_bit_i),
  .watchdog_turn_off_bit_i(watchdog_turn_off_bit_i), .evt_o(evt_o),
  .wdog_on_o(wdog_on_o), .wdog_warn_o(wdog_warn_o), .wdog_expire_o(wdog_expire_o));

// ==== testbench/tb_stw_top.sv ====
// Purpose: self-checking bench of the slow timer and watchdog block
// Assumes: ticks made here, 1 kHz every 5 cycles, crystal every 3
// Notes:   reset reads from a table, then hand-written cases
`timescale 1ns/10ps
`include "stw_regs.svh"
module tb_stw_top
  import stw_pkg::*;
;
  logic        clk_i, rst_n_i, wr_i, rd_i, halted_i;  // bench drives
  logic [31:0] addr_i, wdata_i, rdata_o;               // register port
  logic        calibrated_khz_tick_i, crystal_watch_tick_i;  // ticks
  logic        watchdog_turn_on_bit_i, watchdog_turn_off_bit_i;
  logic        wdog_on_o, wdog_warn_o, wdog_expire_o;  // watchdog
  stw_evt_t    evt_o;                                  // timer events
  logic [2:0]  kdiv = 3'h0;                            // 1 kHz divider
  logic [1:0]  xdiv = 2'h0;                            // crystal divider
  int          num_errors = 0;                         // mismatches
  int          compares = 0;                           // checks made
  int          n, i;                                   // loop counts
  logic [63:0] rows [11] = '{{`STW_ADDR_ARM, 32'h0}, {`STW_ADDR_KICK, 32'h0},
    {`STW_ADDR_CFG, 32'h400}, {`STW_ADDR_CNT_UPPER, 32'h0},
    {`STW_ADDR_CNT_LOWER, 32'h0}, {`STW_ADDR_MA_UPPER, 32'hffff},
    {`STW_ADDR_MA_LOWER, 32'hffff}, {`STW_ADDR_MB_UPPER, 32'hffff},
    {`STW_ADDR_MB_LOWER, 32'hffff}, {32'h4000_6000, 32'h0}, {32'h4000_6028, 32'h0}};

  stw_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .calibrated_khz_tick_i(calibrated_khz_tick_i),
    .crystal_watch_tick_i(crystal_watch_tick_i), .halted_i(halted_i),
    .watchdog_turn_on_bit_i(watchdog_turn_on_bit_i),
    .watchdog_turn_off_bit_i(watchdog_turn_off_bit_i), .evt_o(evt_o),
    .wdog_on_o(wdog_on_o), .wdog_warn_o(wdog_warn_o), .wdog_expire_o(wdog_expire_o));

  ////////////////////////////////////////////////////////////
  // clock and free-running tick pulses
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    kdiv <= (kdiv == 3'h4) ? 3'h0 : kdiv + 3'h1;
    xdiv <= (xdiv == 2'h2) ? 2'h0 : xdiv + 2'h1;
    calibrated_khz_tick_i <= (kdiv == 3'h4);
    crystal_watch_tick_i  <= (xdiv == 2'h2);
  end

  ////////////////////////////////////////////////////////////
  // compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdreg(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, exp, "register read");
  endtask
  // release halt, await one event, freeze, read count
  task automatic wait_evt(input int b, input logic [31:0] c);
    @(posedge clk_i);
    halted_i <= 1'b0;
    for (i = 0; i < 400 && evt_o[b] !== 1'b1; i++) @(negedge clk_i);
    chk({31'h0, evt_o[b]}, 32'h1, "event seen");
    @(posedge clk_i);
    halted_i <= 1'b1;
    rdreg(`STW_ADDR_CNT_UPPER, {16'h0, c[31:16]});
    rdreg(`STW_ADDR_CNT_LOWER, {16'h0, c[15:0]});
  endtask
  task automatic pulse(input logic off, input logic exp);
    @(posedge clk_i);
    watchdog_turn_on_bit_i  <= ~off;
    watchdog_turn_off_bit_i <= off;
    @(posedge clk_i);
    watchdog_turn_on_bit_i  <= 1'b0;
    watchdog_turn_off_bit_i <= 1'b0;
    @(negedge clk_i);
    chk({31'h0, wdog_on_o}, {31'h0, exp}, "watchdog state");
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n_i, wr_i, rd_i, watchdog_turn_on_bit_i, watchdog_turn_off_bit_i} = 5'h0;
    halted_i = 1'b1;
    addr_i  = 32'h0;
    wdata_i = 32'h0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[k]) rdreg(rows[k][63:32], rows[k][31:0]);
    // down count held while halted, then wrap from zero
    wr(`STW_ADDR_CFG, 32'h1c00);
    repeat (40) @(posedge clk_i);
    rdreg(`STW_ADDR_CNT_UPPER, 32'h0);
    rdreg(`STW_ADDR_CNT_LOWER, 32'h0);
    wait_evt(0, 32'hffffffff);
    wr(`STW_ADDR_CFG, 32'h0c71);
    rdreg(`STW_ADDR_CFG, 32'h1c00);
    wr(`STW_ADDR_CFG, 32'h0400);
    rdreg(`STW_ADDR_CFG, 32'h1400);
    wr(`STW_ADDR_CFG, 32'h0400);
    rdreg(`STW_ADDR_CFG, 32'h0400);
    // matches load only on the upper write
    wr(`STW_ADDR_MA_LOWER, 32'h2);
    rdreg(`STW_ADDR_MA_LOWER, 32'hffff);
    wr(`STW_ADDR_MA_UPPER, 32'h0);
    rdreg(`STW_ADDR_MA_LOWER, 32'h2);
    rdreg(`STW_ADDR_MA_UPPER, 32'h0);
    wr(`STW_ADDR_MB_LOWER, 32'h4);
    rdreg(`STW_ADDR_MB_LOWER, 32'hffff);
    wr(`STW_ADDR_MB_UPPER, 32'h0);
    rdreg(`STW_ADDR_MB_LOWER, 32'h4);
    wr(`STW_ADDR_CFG, 32'h0c00);
    wait_evt(1, 32'h2);
    wait_evt(2, 32'h4);
    // crystal, divide by four, no freeze: counts on through the halt
    wr(`STW_ADDR_CFG, 32'h0400);
    repeat (30) @(posedge clk_i);
    wr(`STW_ADDR_MA_LOWER, 32'h6);
    wr(`STW_ADDR_MA_UPPER, 32'h0);
    wr(`STW_ADDR_MB_LOWER, 32'h7);
    wr(`STW_ADDR_MB_UPPER, 32'h0);
    wr(`STW_ADDR_CFG, 32'h0821);
    rdreg(`STW_ADDR_CFG, 32'h0821);
    for (i = 0; i < 400 && evt_o.cmp_a !== 1'b1; i++) @(negedge clk_i);
    n = 0;
    for (i = 0; i < 400 && evt_o.cmp_b !== 1'b1; i++) begin
      @(negedge clk_i);
      n += crystal_watch_tick_i;
    end
    chk(n, 32'h4, "ticks per step");
    // watchdog arming keys
    pulse(1'b0, 1'b0);
    wr(`STW_ADDR_ARM, 32'hdead);
    pulse(1'b0, 1'b0);
    wr(`STW_ADDR_ARM, 32'heabe);
    pulse(1'b0, 1'b1);
    repeat (5000) @(posedge clk_i);
    wr(`STW_ADDR_KICK, 32'h0);
    n = 0;
    for (i = 0; i < 12000 && wdog_warn_o !== 1'b1; i++) begin
      @(negedge clk_i);
      n += calibrated_khz_tick_i;
    end
    chk(n, 32'd1792, "ticks to warning");
    for (i = 0; i < 2000 && wdog_expire_o !== 1'b1; i++) begin
      @(negedge clk_i);
      n += calibrated_khz_tick_i;
    end
    chk(n, 32'd2048, "ticks to timeout");
    wr(`STW_ADDR_ARM, 32'heabe);
    pulse(1'b1, 1'b1);
    wr(`STW_ADDR_ARM, 32'hdead);
    pulse(1'b1, 1'b0);
    tally_and_finish();
  end
endmodule
